// ===== shared/psr_pkg.sv
// Package for the parallel/serial shift register block.
// Assumes a single 200 MHz system clock with all pins sampled in that domain.
package psr_pkg;
    localparam int unsigned            STAGES        = 8;
    localparam int unsigned            FIFO_DEPTH    = 8;
    localparam int unsigned            FIFO_WIDTH    = 1;
    localparam logic [STAGES-1:0]      STAGES_RESET  = 8'h00;
    localparam logic                   GATE_RESET    = 1'h1;
    localparam int unsigned            CLK_PERIOD_PS = 5000;
endpackage : psr_pkg

// ===== src/psr_shift_register.sv
// Eight-stage parallel-in/serial-in, serial-out register with a gated clock,
// an overriding clear and an output FIFO that collects the last stage per clocking, load or shift.
// Assumes all control and data pins are asynchronous to I_REF_CLK.
`timescale 1ns/10ps

module psr_fifo #(
    parameter int unsigned WIDTH = psr_pkg::FIFO_WIDTH,
    parameter int unsigned DEPTH = psr_pkg::FIFO_DEPTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || WIDTH < 1)
        begin : g_bad_params
            $error("psr_fifo needs DEPTH of at least 2 and WIDTH of at least 1.");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [CNT_W-1:0]            count;
    } psr_fifo_s;

    psr_fifo_s state_ff;
    psr_fifo_s nxt_state;
    logic      push;
    logic      pop;

    assign o_in_ready  = (state_ff.count != CNT_W'(DEPTH));
    assign o_out_valid = (state_ff.count != '0);
    assign o_out_data  = state_ff.mem[state_ff.rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb
    begin
        nxt_state = state_ff;
        if (push)
        begin
            nxt_state.mem[state_ff.wr_ptr] = i_in_data;
            nxt_state.wr_ptr = (state_ff.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : state_ff.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            nxt_state.rd_ptr = (state_ff.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : state_ff.rd_ptr + 1'b1;
        end
        case ({push, pop})
            2'b10:   nxt_state.count = state_ff.count + 1'b1;
            2'b01:   nxt_state.count = state_ff.count - 1'b1;
            default: nxt_state.count = state_ff.count;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end
endmodule : psr_fifo

// Contract
// - A high select chains all eight stages into one shift path advanced on each effective rising clock edge.
// - On a shift the first stage takes the serial input and each later stage takes the old value of its predecessor.
// - A low select loads all eight parallel inputs at the next effective rising clock edge and not earlier.
// - During a parallel load the serial input reaches no stage.
// - Clock and clock hold are combined through a two-input NOR and the gated rising clock edge is acted upon.
// - While clock or clock hold is high no clocking happens and every stage keeps its value.
// - Holding one of the two clock inputs low lets the other act as the clock, so a free clock can be paused.
// - An asserted active-low clear zeroes all eight stages and overrides clock, hold, select and data.
// - Only the last stage is visible as the serial output; the earlier stages stay internal.
module psr_shift_register #(
    parameter int unsigned STAGES     = psr_pkg::STAGES,
    parameter int unsigned FIFO_DEPTH = psr_pkg::FIFO_DEPTH
) (
    input  wire logic              I_REF_CLK,
    input  wire logic              I_RESET,
    input  wire logic              I_CLK,
    input  wire logic              I_CLOCK_HOLD_INPUT,
    input  wire logic              I_SHIFT_OR_LOAD_SELECT,
    input  wire logic              I_SERIAL_DATA_IN,
    input  wire logic [STAGES-1:0] I_PARALLEL_DATA,
    input  wire logic              I_ASYNC_CLEAR_N,
    output logic                   O_LAST_STAGE_OUT,
    output logic                   O_STALLED,
    output logic                   O_STREAM_VALID,
    output logic                   O_STREAM_DATA,
    input  wire logic              I_STREAM_READY
);
    generate
        if (STAGES < 2 || FIFO_DEPTH < 2)
        begin : g_bad_params
            $error("psr_shift_register needs at least two stages and a FIFO depth of at least two.");
        end
    endgenerate

    // Every clock, hold, select, serial, clear and parallel pin passes two flip-flops; the s1 copies feed only the s2 copies.
    typedef struct packed {
        logic              s1_clk;
        logic              s1_hold;
        logic              s1_select;
        logic              s1_serial;
        logic              s1_clear_n;
        logic [STAGES-1:0] s1_parallel;
        logic              s2_clk;
        logic              s2_hold;
        logic              s2_select;
        logic              s2_serial;
        logic              s2_clear_n;
        logic [STAGES-1:0] s2_parallel;
        logic              gate_prev;
        logic              stalled;
        logic [STAGES-1:0] stages;
    } psr_state_s;

    psr_state_s state_ff;
    psr_state_s nxt_state;
    logic       gate_now;
    logic       edge_seen;
    logic       fifo_ready;
    logic       advance;

    // The NOR output low means clocking is blocked; its falling side is the flip-flop edge.
    assign gate_now  = state_ff.s2_clk | state_ff.s2_hold;
    assign edge_seen = !state_ff.gate_prev && gate_now;
    assign advance   = edge_seen && fifo_ready && state_ff.s2_clear_n;

    always_comb
    begin
        nxt_state             = state_ff;
        nxt_state.s1_clk      = I_CLK;
        nxt_state.s1_hold     = I_CLOCK_HOLD_INPUT;
        nxt_state.s1_select   = I_SHIFT_OR_LOAD_SELECT;
        nxt_state.s1_serial   = I_SERIAL_DATA_IN;
        nxt_state.s1_clear_n  = I_ASYNC_CLEAR_N;
        nxt_state.s1_parallel = I_PARALLEL_DATA;
        nxt_state.s2_clk      = state_ff.s1_clk;
        nxt_state.s2_hold     = state_ff.s1_hold;
        nxt_state.s2_select   = state_ff.s1_select;
        nxt_state.s2_serial   = state_ff.s1_serial;
        nxt_state.s2_clear_n  = state_ff.s1_clear_n;
        nxt_state.s2_parallel = state_ff.s1_parallel;
        nxt_state.gate_prev   = gate_now;
        nxt_state.stalled     = edge_seen && !fifo_ready;
        if (!state_ff.s2_clear_n)
        begin
            nxt_state.stages = psr_pkg::STAGES_RESET;
        end
        else if (advance)
        begin
            if (state_ff.s2_select)
            begin
                nxt_state.stages = {state_ff.stages[STAGES-2:0], state_ff.s2_serial};
            end
            else
            begin
                nxt_state.stages = state_ff.s2_parallel;
            end
        end
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_RESET)
        begin
            // The synchronised clock copies restart blocked as well, so a clock pin that idles high
            // through reset is not seen as a fresh rising edge once the synchronisers refill.
            state_ff           <= '0;
            state_ff.s1_clk    <= psr_pkg::GATE_RESET;
            state_ff.s2_clk    <= psr_pkg::GATE_RESET;
            state_ff.gate_prev <= psr_pkg::GATE_RESET;
            state_ff.stages    <= psr_pkg::STAGES_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Each clocking of the register pushes the new last-stage value; a full FIFO stalls clocking.
    psr_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (I_REF_CLK),
        .i_reset     (I_RESET),
        .i_in_valid  (advance),
        .i_in_data   (nxt_state.stages[STAGES-1]),
        .o_in_ready  (fifo_ready),
        .o_out_valid (O_STREAM_VALID),
        .o_out_data  (O_STREAM_DATA),
        .i_out_ready (I_STREAM_READY)
    );

    assign O_LAST_STAGE_OUT = state_ff.stages[STAGES-1];
    assign O_STALLED        = state_ff.stalled;
endmodule : psr_shift_register

// ===== test/psr_host.sv
// Host model driving the register pins of the shift register.
// Assumes calls are timed from the system clock.
`timescale 1ns/10ps
module psr_host (
    input  wire logic  i_ref_clk,
    output logic       o_clk,
    output logic       o_hold,
    output logic       o_sel,
    output logic       o_ser,
    output logic [7:0] o_par,
    output logic       o_clear_n
);
    initial
    begin
        {o_clk, o_hold, o_sel, o_ser, o_par, o_clear_n} = {1'h1, 11'h000, 1'h1};
    end
    // The clock pin idles high, so the data set up here is stable around each rise.
    task automatic pulse(input logic sel, input logic serial_data_in, input logic [7:0] par);
        @(posedge i_ref_clk);
        {o_sel, o_ser, o_par} <= {sel, serial_data_in, par};
        o_clk <= 1'h0;
        repeat (3) @(posedge i_ref_clk);
        o_clk <= 1'h1;
        repeat (6) @(posedge i_ref_clk);
    endtask : pulse
    task automatic set_hold(input logic v);
        @(posedge i_ref_clk);
        o_hold <= v;
    endtask : set_hold
    task automatic clear(input int n);
        @(posedge i_ref_clk);
        o_clear_n <= 1'h0;
        repeat (n) @(posedge i_ref_clk);
        o_clear_n <= 1'h1;
    endtask : clear
endmodule : psr_host

// ===== test/psr_chk.sv
// Port checker for the shift register.
// Assumes pins stay stable around each clock pin rise.
`timescale 1ns/10ps
module psr_chk #(
    parameter int unsigned STAGES = 8
) (
    input wire logic              I_REF_CLK,
    input wire logic              I_RESET,
    input wire logic              I_CLK,
    input wire logic              I_CLOCK_HOLD_INPUT,
    input wire logic              I_SHIFT_OR_LOAD_SELECT,
    input wire logic              I_SERIAL_DATA_IN,
    input wire logic [STAGES-1:0] I_PARALLEL_DATA,
    input wire logic              I_ASYNC_CLEAR_N,
    input wire logic              O_LAST_STAGE_OUT,
    input wire logic              O_STALLED,
    input wire logic              O_STREAM_VALID,
    input wire logic              O_STREAM_DATA,
    input wire logic              I_STREAM_READY
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);
    sequence load_edge;
        !I_CLK [*2] ##1 I_CLK && !I_SHIFT_OR_LOAD_SELECT && !I_CLOCK_HOLD_INPUT && I_ASYNC_CLEAR_N && !O_STREAM_VALID;
    endsequence
    load_value_a: assert property (load_edge |-> ##4 O_LAST_STAGE_OUT == $past(I_PARALLEL_DATA[STAGES-1], 4))
        else $error("load value wrong");
    hold_keep_a: assert property ((I_CLOCK_HOLD_INPUT && I_ASYNC_CLEAR_N) [*6] |-> $stable(O_LAST_STAGE_OUT))
        else $error("output moved under hold");
    clear_zero_a: assert property (!I_ASYNC_CLEAR_N [*5] |-> !O_LAST_STAGE_OUT)
        else $error("clear did not zero");
    out_cause_a: assert property ($changed(O_LAST_STAGE_OUT) |-> $past(I_RESET) || !$past(I_ASYNC_CLEAR_N, 3)
        || ($past(I_CLK, 3) && !$past(I_CLK, 4)))
        else $error("output changed without edge");
    stream_head_a: assert property ($rose(O_STREAM_VALID) |-> O_STREAM_DATA == O_LAST_STAGE_OUT)
        else $error("stream head differs");
    valid_hold_a: assert property (O_STREAM_VALID && !I_STREAM_READY |=> O_STREAM_VALID && $stable(O_STREAM_DATA))
        else $error("stream head dropped");
    stall_pulse_a: assert property (O_STALLED |-> O_STREAM_VALID ##1 !O_STALLED)
        else $error("bad stall pulse");
    reset_idle_a: assert property (disable iff (1'b0) I_RESET |=> !O_STREAM_VALID && !O_LAST_STAGE_OUT && !O_STALLED)
        else $error("outputs busy after reset");
endmodule : psr_chk
bind psr_shift_register psr_chk #(.STAGES(STAGES)) psr_chk_i (.*);

// ===== test/testbench.sv
// Self-checking bench: load, shift, stall, drain, hold and clear.
// Assumes the host model drives the register pins.
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic       I_REF_CLK = 1'h0, I_RESET = 1'h1, I_STREAM_READY = 1'h0, stall_seen = 1'h0;
    logic       I_CLK, I_CLOCK_HOLD_INPUT, I_SHIFT_OR_LOAD_SELECT, I_SERIAL_DATA_IN, I_ASYNC_CLEAR_N;
    logic [7:0] I_PARALLEL_DATA;
    logic       O_LAST_STAGE_OUT, O_STALLED, O_STREAM_VALID, O_STREAM_DATA;
    int         err_count = 0, samples_checked = 0, cycles = 0;
    psr_shift_register psr_shift_register_i (.*);
    psr_host psr_host_i (.i_ref_clk(I_REF_CLK), .o_clk(I_CLK), .o_hold(I_CLOCK_HOLD_INPUT),
        .o_sel(I_SHIFT_OR_LOAD_SELECT), .o_ser(I_SERIAL_DATA_IN), .o_par(I_PARALLEL_DATA),
        .o_clear_n(I_ASYNC_CLEAR_N));
    always #2.5 I_REF_CLK = ~I_REF_CLK;
    always @(posedge I_REF_CLK)
    begin
        stall_seen <= !I_RESET && (stall_seen || O_STALLED === 1'h1);
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            err_count++;
            close_out();
        end
    end
    task automatic drain(input logic [7:0] exp, input int n);
        int k;
        I_STREAM_READY <= 1'h1;
        for (int i = n - 1; i >= 0; i--)
        begin
            k = 0;
            do @(posedge I_REF_CLK); while (O_STREAM_VALID !== 1'h1 && k++ < 20);
            `CHK("stream bit", exp[i], O_STREAM_DATA)
        end
        I_STREAM_READY <= 1'h0;
        @(posedge I_REF_CLK);
        `CHK("stream empty", 1'h0, O_STREAM_VALID)
    endtask : drain
    task automatic t_stream();
        psr_host_i.pulse(1'h0, 1'h1, 8'ha4);
        `CHK("after load", 1'h1, O_LAST_STAGE_OUT)
        repeat (7) psr_host_i.pulse(1'h1, 1'h1, 8'h00);
        `CHK("after shifts", 1'h0, O_LAST_STAGE_OUT)
        psr_host_i.pulse(1'h1, 1'h1, 8'h00);
        `CHK("stall seen", 1'h1, stall_seen)
        `CHK("stalled stage", 1'h0, O_LAST_STAGE_OUT)
        drain(8'ha4, 8);
    endtask : t_stream
    task automatic t_hold();
        psr_host_i.set_hold(1'h1);
        psr_host_i.pulse(1'h0, 1'h0, 8'hff);
        `CHK("held stage", 1'h0, O_LAST_STAGE_OUT)
        psr_host_i.set_hold(1'h0);
        psr_host_i.pulse(1'h0, 1'h0, 8'hff);
        `CHK("released stage", 1'h1, O_LAST_STAGE_OUT)
        drain(8'h01, 1);
    endtask : t_hold
    task automatic t_clear();
        psr_host_i.clear(6);
        repeat (5) @(posedge I_REF_CLK);
        `CHK("cleared stage", 1'h0, O_LAST_STAGE_OUT)
        drain(8'h00, 0);
    endtask : t_clear
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (3) @(posedge I_REF_CLK);
        I_RESET <= 1'h0;
        repeat (4) @(posedge I_REF_CLK);
        t_stream();
        t_hold();
        t_clear();
        close_out();
    end
endmodule : testbench
